// ==== llb_consts.svh ====
// Purpose: offsets, reset values and counts of the legacy link byte block
// Assumes: 8-bit host port, registers at their printed offsets
// Notes: definitions only
`ifndef LLB_CONSTS_SVH
`define LLB_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LLB_OFS_RX_BYTE 8'hC0
`define LLB_OFS_TX_BYTE 8'hC1
`define LLB_OFS_MATCH_A 8'hC2
`define LLB_OFS_MATCH_B 8'hC3

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define LLB_RST_BYTE 8'h00
`define LLB_UNMAPPED_DATA 8'h00
`define LLB_BITS_PER_BYTE 4'h8
`define LLB_STUFF_RUN 3'h5
`define LLB_RUN_SAT 3'h7
`define LLB_BYTE_PERIOD_US 2000

`endif

// ==== llb_framer_model.sv ====
// Purpose: framer-side stream model facing the link byte block
// Assumes: single sys_clk; all changes on the falling edge
// Notes: gap selects prompt or slow pacing of bits and slots
`timescale 1ns/1ps
`default_nettype none
module llb_framer_model (
  // clock
  input wire logic sys_clk,
  // receive stream
  output logic rx_bit_valid,
  output logic rx_bit,
  // transmit slots
  output logic tx_slot,
  output logic tx_mf_boundary,
  input wire logic tx_bit,
  input wire logic tx_bit_valid
);
  int gap = 0;
  initial begin
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
    tx_slot = 1'b0;
    tx_mf_boundary = 1'b0;
  end
  // ----------------------------------------
  // stream tasks
  // ----------------------------------------
  // idle line shows the inverse, so a stale bit never looks valid
  task automatic put_bit(input logic b);
    @(negedge sys_clk);
    rx_bit_valid = 1'b1;
    rx_bit = b;
    @(negedge sys_clk);
    rx_bit_valid = 1'b0;
    rx_bit = ~b;
    repeat (gap) @(negedge sys_clk);
  endtask
  task automatic slot(output logic b, output logic v);
    @(negedge sys_clk);
    tx_slot = 1'b1;
    @(negedge sys_clk);
    tx_slot = 1'b0;
    b = tx_bit;
    v = tx_bit_valid;
    repeat (gap) @(negedge sys_clk);
  endtask
  task automatic mf();
    @(negedge sys_clk);
    tx_mf_boundary = 1'b1;
    @(negedge sys_clk);
    tx_mf_boundary = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== llb_link_byte.sv ====
// Purpose: byte-wide link extract and insert path of a T1 framer
// Assumes: link bit strobes come from framer logic on sys_clk
// Notes: status flags latch until a status read; int_n is active low
`timescale 1ns/1ps
`default_nettype none
`include "llb_consts.svh"

module llb_link_byte (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host port
  input wire llb_pkg::llb_host_req_t host_req,
  input wire logic status_rd,
  output logic [7:0] host_rdata,
  // control bits
  input wire llb_pkg::llb_ctrl_t ctrl,
  // receive link stream
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  // transmit link stream
  input wire logic tx_slot,
  input wire logic tx_mf_boundary,
  output logic tx_bit,
  output logic tx_bit_valid,
  // status and interrupt
  output llb_pkg::llb_status_t status,
  output logic int_n
);
  import llb_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // set beats clear so no event is lost under a read
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction

  function automatic logic [2:0] run_next(input logic [2:0] run, input logic bit_in);
    if (!bit_in) begin
      run_next = 3'h0;
    end else if (run == `LLB_RUN_SAT) begin
      run_next = run;
    end else begin
      run_next = run + 3'h1;
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] rx_byte_ff;
  logic [7:0] tx_byte_ff;
  logic [7:0] match_a_ff;
  logic [7:0] match_b_ff;
  logic [7:0] rx_shift_ff;
  logic [3:0] rx_cnt_ff;
  logic [2:0] rx_run_ff;
  logic [7:0] tx_shift_ff;
  logic [3:0] tx_cnt_ff;
  logic [2:0] tx_run_ff;
  logic [7:0] host_rdata_ff;
  logic tx_bit_ff;
  logic tx_bit_valid_ff;
  llb_status_t status_ff;
  logic int_n_ff;

  logic rx_drop;
  logic rx_take;
  logic [7:0] rx_assembled;
  logic rx_done;
  logic rx_match;
  logic tx_stuff;
  logic tx_send;
  logic tx_done;
  logic tx_gate;
  logic tx_load;
  llb_status_t nxt_status;
  logic nxt_int_n;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_byte_ff <= `LLB_RST_BYTE;
      match_a_ff <= `LLB_RST_BYTE;
      match_b_ff <= `LLB_RST_BYTE;
    end else if (host_req.wr) begin
      case (host_req.addr)
        `LLB_OFS_TX_BYTE: tx_byte_ff <= host_req.wdata;
        `LLB_OFS_MATCH_A: match_a_ff <= host_req.wdata;
        `LLB_OFS_MATCH_B: match_b_ff <= host_req.wdata;
        default: ;
      endcase
    end
  end

  // read data registered one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      host_rdata_ff <= `LLB_UNMAPPED_DATA;
    end else if (host_req.rd) begin
      case (host_req.addr)
        `LLB_OFS_RX_BYTE: host_rdata_ff <= rx_byte_ff;
        `LLB_OFS_TX_BYTE: host_rdata_ff <= tx_byte_ff;
        `LLB_OFS_MATCH_A: host_rdata_ff <= match_a_ff;
        `LLB_OFS_MATCH_B: host_rdata_ff <= match_b_ff;
        default: host_rdata_ff <= `LLB_UNMAPPED_DATA;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  // a zero after exactly five ones is stuffing; longer runs are flags
  assign rx_drop = ctrl.rx_destuff_enable && !rx_bit && rx_run_ff == `LLB_STUFF_RUN;
  assign rx_take = rx_bit_valid && !rx_drop;
  assign rx_assembled = {rx_bit, rx_shift_ff[7:1]};
  assign rx_done = rx_take && rx_cnt_ff == `LLB_BITS_PER_BYTE - 4'h1;
  assign rx_match = rx_assembled == match_a_ff || rx_assembled == match_b_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_run_ff <= 3'h0;
    end else if (rx_bit_valid) begin
      rx_run_ff <= run_next(rx_run_ff, rx_bit);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_shift_ff <= `LLB_RST_BYTE;
      rx_cnt_ff <= 4'h0;
    end else if (rx_take) begin
      rx_shift_ff <= rx_assembled;
      rx_cnt_ff <= rx_done ? 4'h0 : rx_cnt_ff + 4'h1;
    end
  end

  // unread byte is simply overwritten by the next one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_byte_ff <= `LLB_RST_BYTE;
    end else if (rx_done) begin
      rx_byte_ff <= rx_assembled;
    end
  end

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  assign tx_stuff = ctrl.tx_stuff_enable && tx_run_ff == `LLB_STUFF_RUN;
  assign tx_send = tx_slot && !tx_stuff;
  assign tx_done = tx_send && tx_cnt_ff == `LLB_BITS_PER_BYTE - 4'h1;
  assign tx_gate = ctrl.d4_mode && ctrl.tx_multiframe_load_enable;
  // reload from the byte register, which still holds the old value if unwritten
  assign tx_load = tx_gate ? tx_mf_boundary : tx_done;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_shift_ff <= `LLB_RST_BYTE;
      tx_cnt_ff <= 4'h0;
    end else if (tx_load) begin
      tx_shift_ff <= tx_byte_ff;
      tx_cnt_ff <= 4'h0;
    end else if (tx_send) begin
      tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
      tx_cnt_ff <= tx_done ? 4'h0 : tx_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_run_ff <= 3'h0;
    end else if (tx_slot) begin
      tx_run_ff <= run_next(tx_run_ff, tx_send & tx_shift_ff[0]);
    end
  end

  // in D4 with an outside Fs source the slot is not ours
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_bit_ff <= 1'b0;
      tx_bit_valid_ff <= 1'b0;
    end else begin
      tx_bit_ff <= tx_send & tx_shift_ff[0];
      tx_bit_valid_ff <= tx_slot && !(ctrl.d4_mode && ctrl.tx_fs_source_select);
    end
  end

  // ----------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    nxt_status.rx_byte_full_flag = flag_next(status_ff.rx_byte_full_flag, rx_done, status_rd);
    nxt_status.rx_match_flag = flag_next(status_ff.rx_match_flag, rx_done & rx_match, status_rd);
    nxt_status.tx_byte_empty_flag = flag_next(status_ff.tx_byte_empty_flag, tx_done, status_rd);
    nxt_int_n = !((nxt_status.rx_byte_full_flag & ctrl.rx_byte_full_mask) |
                  (nxt_status.rx_match_flag & ctrl.rx_match_mask) |
                  (nxt_status.tx_byte_empty_flag & ctrl.tx_byte_empty_mask));
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_ff <= '0;
      int_n_ff <= 1'b1;
    end else begin
      status_ff <= nxt_status;
      int_n_ff <= nxt_int_n;
    end
  end

  assign host_rdata = host_rdata_ff;
  assign tx_bit = tx_bit_ff;
  assign tx_bit_valid = tx_bit_valid_ff;
  assign status = status_ff;
  assign int_n = int_n_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence rx_byte_end_s;
    rx_done;
  endsequence

  sequence five_ones_s;
    rx_bit_valid && rx_bit && ctrl.rx_destuff_enable && rx_run_ff == 3'h4;
  endsequence

  rx_full_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_byte_end_s |=> status_ff.rx_byte_full_flag && rx_byte_ff == $past(rx_assembled))
    else $error("full flag or byte missing after eighth bit");

  rx_lsb_first_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_done |=> rx_byte_ff[7] == $past(rx_bit))
    else $error("last received bit not in msb");

  rx_full_irq_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_done && ctrl.rx_byte_full_mask |=> !int_n)
    else $error("interrupt not low on full event");

  rx_match_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_done && rx_match |=> status_ff.rx_match_flag)
    else $error("match flag not set");

  rx_destuff_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
    // with gap at 0 the framer paces its bits with one idle cycle between them
    five_ones_s ##1 !rx_bit_valid ##1 (rx_bit_valid && !rx_bit && ctrl.rx_destuff_enable)
    |=> $stable(rx_cnt_ff))
    else $error("stuffed zero was kept");

  rx_long_run_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_bit_valid && !rx_bit && rx_run_ff > 3'h5 |=> rx_cnt_ff != $past(rx_cnt_ff))
    else $error("zero after long run was dropped");

  tx_empty_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_done |=> status_ff.tx_byte_empty_flag
    ##0 (!int_n || !ctrl.tx_byte_empty_mask))
    else $error("empty flag or interrupt missing");

  tx_resend_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_done && !tx_gate |=> tx_shift_ff == $past(tx_byte_ff) && tx_cnt_ff == 4'h0)
    else $error("serialiser not reloaded after byte");

  tx_stuff_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_slot && ctrl.tx_stuff_enable && tx_run_ff == 3'h5 |=> !tx_bit_ff)
    else $error("no zero after five ones");

  tx_mf_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_gate && !tx_mf_boundary && tx_cnt_ff != 4'h7 ##1 tx_gate && !tx_mf_boundary
    |-> tx_cnt_ff != 4'h0 || !$past(tx_send))
    else $error("serialiser loaded off multiframe boundary");

  flag_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_ff.rx_byte_full_flag && !status_rd |=> status_ff.rx_byte_full_flag)
    else $error("full flag dropped without read");

  irq_level_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_ff.tx_byte_empty_flag && ctrl.tx_byte_empty_mask && $past(ctrl.tx_byte_empty_mask)
    |-> !int_n)
    else $error("interrupt high while enabled flag set");

endmodule
`default_nettype wire

// ==== llb_pkg.sv ====
// Purpose: types shared by the legacy link byte block
// Assumes: constants come from llb_consts.svh
// Notes: host request and control bits travel as packed structs
package llb_pkg;

  // host access, one cycle per strobe
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } llb_host_req_t;

  // software control bits
  typedef struct packed {
    logic d4_mode;
    logic rx_destuff_enable;
    logic tx_stuff_enable;
    logic tx_fs_source_select;
    logic tx_multiframe_load_enable;
    logic rx_byte_full_mask;
    logic rx_match_mask;
    logic tx_byte_empty_mask;
  } llb_ctrl_t;

  // latched status flags
  typedef struct packed {
    logic rx_byte_full_flag;
    logic tx_byte_empty_flag;
    logic rx_match_flag;
  } llb_status_t;

endpackage

// ==== test_legacy_link_byte_insert_extract.sv ====
// Purpose: self-checking bench of the link byte block
// Assumes: stimulus on falling edges, seeded shift register values
// Notes: expectations come from a bench model of rx and tx paths
`timescale 1ns/1ps
`default_nettype none
`include "llb_consts.svh"
module test_legacy_link_byte_insert_extract;
  import llb_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  llb_host_req_t req = '0;
  llb_ctrl_t ctl = '0;
  logic status_rd = 1'b0;
  logic [7:0] rdata;
  logic rxv, rxb, slot, mfb, txb, txv, int_n;
  llb_status_t st;
  int n_mismatch = 0;
  int compares = 0;
  logic [31:0] seed = 32'h8FB4;
  logic [7:0] ma = 8'h00, mb = 8'h00, txr = 8'h00, rx_exp = 8'h00, tx_sh = 8'h00, v;
  int rx_n = 0, rrun = 0, tx_i = 0, trun = 0;
  logic e_full = 1'b0, e_emp = 1'b0, e_mt = 1'b0;
  always #5 sys_clk = ~sys_clk;
  llb_link_byte dut_u (.sys_clk(sys_clk), .rst(rst), .host_req(req), .status_rd(status_rd),
    .host_rdata(rdata), .ctrl(ctl), .rx_bit_valid(rxv), .rx_bit(rxb), .tx_slot(slot),
    .tx_mf_boundary(mfb), .tx_bit(txb), .tx_bit_valid(txv), .status(st), .int_n(int_n));
  llb_framer_model fm (.sys_clk(sys_clk), .rx_bit_valid(rxv), .rx_bit(rxb), .tx_slot(slot),
    .tx_mf_boundary(mfb), .tx_bit(txb), .tx_bit_valid(txv));
  // ----------------------------------------
  // checking and host access
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_int();
    return !((e_full & ctl.rx_byte_full_mask) | (e_mt & ctl.rx_match_mask) |
      (e_emp & ctl.tx_byte_empty_mask));
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic host(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(negedge sys_clk);
    req = {a, w, ~w, d};
    if (w && a == `LLB_OFS_TX_BYTE) txr = d;
    if (w && a == `LLB_OFS_MATCH_A) ma = d;
    if (w && a == `LLB_OFS_MATCH_B) mb = d;
    @(negedge sys_clk);
    req = '0;
  endtask
  task automatic chkst();
    chk("status", {5'h00, st}, {5'h00, e_full, e_emp, e_mt});
    chk("int_n", {7'h00, int_n}, {7'h00, exp_int()});
  endtask
  task automatic clr();
    @(negedge sys_clk);
    status_rd = 1'b1;
    @(negedge sys_clk);
    status_rd = 1'b0;
    {e_full, e_emp, e_mt} = 3'h0;
    chkst();
  endtask
  // ----------------------------------------
  // stream models
  // ----------------------------------------
  task automatic rx_bits(input logic [15:0] bits, input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      b = bits[i];
      fm.put_bit(b);
      if (!(ctl.rx_destuff_enable && !b && rrun == 5)) begin
        rx_exp = {b, rx_exp[7:1]};
        rx_n++;
      end
      rrun = b ? (rrun == 7 ? 7 : rrun + 1) : 0;
      if (rx_n == 8) begin
        rx_n = 0;
        e_full = 1'b1;
        e_mt = e_mt | (rx_exp == ma) | (rx_exp == mb);
        chkst();
        host(`LLB_OFS_RX_BYTE, 1'b0, 8'h00);
        chk("rx byte", rdata, rx_exp);
        clr();
      end
    end
  endtask
  task automatic tx_slots(input int n);
    logic b, tv, e;
    repeat (n) begin
      fm.slot(b, tv);
      if (ctl.tx_stuff_enable && trun == 5) begin
        e = 1'b0;
        trun = 0;
      end else begin
        e = tx_sh[tx_i];
        trun = e ? (trun == 7 ? 7 : trun + 1) : 0;
        tx_i++;
        if (tx_i == 8) begin
          tx_i = 0;
          e_emp = 1'b1;
          if (!(ctl.d4_mode && ctl.tx_multiframe_load_enable)) tx_sh = txr;
        end
      end
      chk("tx bit", {6'h00, tv, b}, {6'h00, 1'b1, e});
    end
    @(negedge sys_clk);
  endtask
  task automatic give_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #500000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    chkst();
    host(`LLB_OFS_RX_BYTE, 1'b1, 8'hFF);
    host(8'hC4, 1'b1, 8'hFF);
    for (int a = 8'hC0; a <= 8'hC4; a++) begin
      host(a[7:0], 1'b0, 8'h00);
      chk("reset reg", rdata, `LLB_RST_BYTE);
    end
    for (int k = 2; k < 4; k++) begin
      seed = lfsr(seed);
      host(8'hC0 + k[7:0], 1'b1, seed[7:0]);
      host(8'hC0 + k[7:0], 1'b0, 8'h00);
      chk("match reg", rdata, k == 2 ? ma : mb);
    end
    $display("registers done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = i == 1 ? ma : i == 2 ? mb : seed[7:0];
      ctl.rx_byte_full_mask = seed[8];
      ctl.rx_match_mask = seed[9];
      fm.gap = i % 2;
      rx_bits({8'h00, v}, 8);
    end
    $display("receive done");
    ctl.rx_destuff_enable = 1'b1;
    fm.gap = 0;
    rx_bits(16'h01BE, 9);
    rx_bits(16'h003F, 8);
    $display("destuff done");
    ctl.tx_stuff_enable = 1'b1;
    ctl.tx_byte_empty_mask = 1'b1;
    host(`LLB_OFS_TX_BYTE, 1'b1, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      if (i != 4) host(`LLB_OFS_TX_BYTE, 1'b1, seed[7:0]);
      fm.gap = i % 2;
      tx_slots(10);
      chkst();
      clr();
      ctl.tx_stuff_enable = i < 2;
    end
    $display("transmit done");
    ctl.d4_mode = 1'b1;
    ctl.tx_multiframe_load_enable = 1'b1;
    host(`LLB_OFS_TX_BYTE, 1'b1, 8'h1C);
    fm.mf();
    tx_sh = txr;
    tx_i = 0;
    tx_slots(4);
    seed = lfsr(seed);
    host(`LLB_OFS_TX_BYTE, 1'b1, seed[7:0]);
    tx_slots(4);
    fm.mf();
    tx_sh = txr;
    tx_i = 0;
    tx_slots(8);
    ctl.tx_fs_source_select = 1'b1;
    tx_slots(0);
    fm.slot(v[1], v[0]);
    chk("fs valid", {7'h00, v[0]}, 8'h00);
    $display("d4 done");
    give_verdict();
  end
endmodule
`default_nettype wire
